// File: dv/iphs_injector_model.sv
/*
 iphs_injector_model: behavioural injector coil seen from the switches.
 Assumes the switch outputs of iphs_sequencer; gives a current code.
*/
`timescale 1ns/10ps
module iphs_injector_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire iphs_pkg::iphs_sw_t high_side_switch,
   input wire logic low_side_switch,
   output logic [9:0] current
);
   // ----------------------------------------------------------
   // coil current steps
   // ----------------------------------------------------------
   // boost rises fast, battery slowly; open low side decays fast
   wire logic drv_boost = high_side_switch.boost & low_side_switch;
   wire logic drv_bat = high_side_switch.bat & low_side_switch;
   wire logic [9:0] up_step = drv_boost ? 10'h00C : 10'h004;
   wire logic [9:0] dn_step = low_side_switch ? 10'h001 : 10'h006;
   wire logic [9:0] up_val = (current > 10'h3F0) ? 10'h3FF : current + up_step;
   wire logic [9:0] dn_val = (current < dn_step) ? 10'h000 : current - dn_step;
   // saturating, so the code never wraps past full scale
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         current <= 10'h000;
      else
         current <= (drv_boost | drv_bat) ? up_val : dn_val;
   end
endmodule

// File: dv/tb.sv
/*
 tb: self-checking bench for iphs_sequencer with a coil model.
 Assumes one 25 MHz clock; inputs change at the falling edge.
*/
`timescale 1ns/10ps
module tb;
   logic mclk, reset_n, start, boost_ok, use_mdl, cnt1_end, cnt2_end;
   iphs_pkg::iphs_cfg_t cfg;
   iphs_pkg::iphs_diag_t diag_boost, diag_bat, diag_low;
   logic [9:0] cur_frc, cur_mdl, dac_ref;
   iphs_pkg::iphs_sw_t high_side_switch;
   logic low_side_switch, no_target_current, no_boost_voltage;
   logic [2:0] fault_report;
   int err_total, checks, n;
   wire logic [2:0] sw = {high_side_switch.boost, high_side_switch.bat,
                          low_side_switch};
   wire logic [9:0] current = use_mdl ? cur_mdl : cur_frc;

   iphs_sequencer u_dut (.mclk(mclk), .reset_n(reset_n), .start(start),
      .cfg(cfg), .current(current), .boost_ok(boost_ok),
      .diag_boost(diag_boost), .diag_bat(diag_bat), .diag_low(diag_low),
      .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
      .dac_ref(dac_ref), .fault_report(fault_report),
      .no_target_current(no_target_current),
      .no_boost_voltage(no_boost_voltage), .first_counter_expiry(cnt1_end),
      .second_counter_expiry(cnt2_end));
   iphs_injector_model u_load (.mclk(mclk), .reset_n(reset_n),
      .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
      .current(cur_mdl));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // bounded wait for a switch pattern; cyc gives cycles spent
   task automatic wait_sw(input logic [2:0] exp, input int lim,
                          output int cyc);
      cyc = 0;
      while (sw !== exp && cyc < lim) begin
         tick(1);
         cyc++;
      end
      chk(16'(sw), 16'(exp));
      if (sw !== exp)
         report_and_stop();
   endtask
   task automatic rand_cfg;
      cfg.peak_tot = 16'(20 + $urandom_range(0, 31));
      cfg.hold_tot = 16'(30 + $urandom_range(0, 31));
      cfg.peak_off = 16'(4 + $urandom_range(0, 15));
      cfg.hold_off = 16'(4 + $urandom_range(0, 15));
      cfg.peak_thr = 10'(10'h180 + $urandom_range(0, 127));
      cfg.hold_thr = 10'(10'h080 + $urandom_range(0, 127));
      cfg.peak_lo_thr = cfg.peak_thr - 10'h040;
      cfg.hold_lo_thr = cfg.hold_thr - 10'h040;
   endtask

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // coil runs: never both supplies, never a high side with low off
   always @(negedge mclk)
      if (use_mdl) begin
         chk(16'(sw[2] & sw[1]), 16'h0000);
         chk(16'(~sw[0] & (sw[2] | sw[1])), 16'h0000);
      end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      start = 1'b0;
      boost_ok = 1'b1;
      use_mdl = 1'b0;
      cur_frc = 10'h000;
      diag_boost = '0;
      diag_bat = '0;
      diag_low = '0;
      cfg = '0;
      err_total = 0;
      checks = 0;
      void'($urandom(70557));
      rand_cfg();
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      reset_n = 1'b1;
      chk(16'(sw), 16'h0000);
      tick(2);
      // low current, no boost: full peak then full hold by timers
      boost_ok = 1'b0;
      start = 1'b1;
      wait_sw(3'h5, 4, n);
      tick(1);
      chk(16'(no_boost_voltage), 16'h0001);
      wait_sw(3'h3, 300, n);
      chk(16'(n), cfg.peak_tot - 16'h0001);
      chk(16'(no_target_current), 16'h0001);
      chk(16'(dac_ref), 16'(cfg.hold_thr));
      wait_sw(3'h0, 300, n);
      chk(16'(n), cfg.hold_tot);
      start = 1'b0;
      tick(3);
      chk(16'(sw), 16'h0000);
      // high current: alternation, then hold entry straight to off
      boost_ok = 1'b1;
      cur_frc = 10'h3FF;
      start = 1'b1;
      wait_sw(3'h1, 4, n);
      chk(16'(dac_ref), 16'(cfg.peak_thr));
      tick(int'(cfg.peak_off) - 1);
      chk(16'(cnt2_end), 16'h0001);
      chk(16'(cnt1_end), 16'h0000);
      wait_sw(3'h5, 24, n);
      n = 0;
      while (dac_ref !== cfg.hold_thr && n < 200) begin
         tick(1);
         n++;
      end
      chk(16'(dac_ref), 16'(cfg.hold_thr));
      if (dac_ref !== cfg.hold_thr)
         report_and_stop();
      chk(16'(sw), 16'h0001);
      cur_frc = 10'h000;
      tick(int'(cfg.hold_off) - 1);
      chk(16'(cnt1_end), 16'h0001);
      wait_sw(3'h3, 24, n);
      cur_frc = 10'h3FF;
      wait_sw(3'h1, 3, n);
      start = 1'b0;
      wait_sw(3'h0, 3, n);
      tick(3);
      // switch faults: hard shorts open the switch, soft ones report
      cur_frc = 10'h000;
      start = 1'b1;
      wait_sw(3'h5, 4, n);
      diag_boost.short_gnd = 1'b1;
      diag_low.short_gnd = 1'b1;
      wait_sw(3'h1, 3, n);
      chk(16'(fault_report), 16'h0005);
      diag_boost = '0;
      diag_low = '0;
      start = 1'b0;
      wait_sw(3'h0, 3, n);
      tick(3);
      start = 1'b1;
      wait_sw(3'h3, 300, n);
      diag_bat.open_load = 1'b1;
      diag_bat.short_bat = 1'b1;
      tick(2);
      chk(16'(sw), 16'h0003);
      chk(16'(fault_report), 16'h0002);
      diag_low.short_bat = 1'b1;
      tick(2);
      chk(16'(low_side_switch), 16'h0000);
      start = 1'b0;
      diag_bat = '0;
      diag_low = '0;
      tick(4);
      // random pulses on the coil model, both control options
      use_mdl = 1'b1;
      repeat (6) begin
         rand_cfg();
         cfg.two_thr_mode = 1'($urandom_range(0, 1));
         boost_ok = 1'($urandom_range(0, 1));
         tick(2);
         start = 1'b1;
         tick($urandom_range(100, 400));
         start = 1'b0;
         tick(4);
         chk(16'(sw), 16'h0000);
      end
      report_and_stop();
   end
endmodule

// File: logic/iphs_pkg.sv
/*
 iphs_pkg: shared types and constants for the peak and hold injector
 sequencer. Assumes a single 25 MHz system clock domain.
*/
package iphs_pkg;
   // -------------------------------------------------------------
   // widths and reset values
   // -------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int DAC_W = 10;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [9:0] DAC_ZERO = 10'h000;
   localparam int CLK_MHZ = 25;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      IPHS_IDLE,
      IPHS_PEAK_ON,
      IPHS_PEAK_OFF,
      IPHS_HOLD_ON,
      IPHS_HOLD_OFF,
      IPHS_EOINJ
   } iphs_state_t;

   // switch drive bundle, 1 = switch on
   typedef struct packed {
      logic boost;
      logic bat;
      logic low;
   } iphs_sw_t;

   // per-switch diagnostic inputs
   typedef struct packed {
      logic open_load;
      logic short_bat;
      logic short_gnd;
   } iphs_diag_t;

   // programmed sequence settings
   typedef struct packed {
      logic [15:0] peak_tot;
      logic [15:0] peak_off;
      logic [15:0] hold_tot;
      logic [15:0] hold_off;
      logic [9:0] peak_thr;
      logic [9:0] hold_thr;
      logic [9:0] peak_lo_thr;
      logic [9:0] hold_lo_thr;
      logic two_thr_mode;
   } iphs_cfg_t;
endpackage

// File: logic/iphs_sequencer.sv
/*
 iphs_sequencer: peak and hold current shaping for one injector.
 Assumes all inputs are synchronous to mclk; the settings are written
 by a serial port elsewhere and held stable during a pulse.
*/
`timescale 1ns/10ps
module iphs_sequencer #(
   parameter bit TWO_THR_OK = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic start,
   input wire iphs_pkg::iphs_cfg_t cfg,
   input wire logic [iphs_pkg::DAC_W-1:0] current,
   input wire logic boost_ok,
   input wire iphs_pkg::iphs_diag_t diag_boost,
   input wire iphs_pkg::iphs_diag_t diag_bat,
   input wire iphs_pkg::iphs_diag_t diag_low,
   output iphs_pkg::iphs_sw_t high_side_switch,
   output logic low_side_switch,
   output logic [iphs_pkg::DAC_W-1:0] dac_ref,
   output logic [2:0] fault_report,
   output logic no_target_current,
   output logic no_boost_voltage,
   output logic first_counter_expiry,
   output logic second_counter_expiry
);
   // -------------------------------------------------------------
   // state and counters
   // -------------------------------------------------------------
   iphs_pkg::iphs_state_t state_reg, state_next;
   logic [15:0] cnt1_reg, cnt2_reg;
   logic start_reg;
   logic [2:0] kill_reg;
   logic reached_reg;
   iphs_pkg::iphs_sw_t sw_reg, sw_next;
   logic [9:0] dac_next;

   wire start_rise = start & ~start_reg;
   wire start_fall = ~start & start_reg;
   wire two_thr = TWO_THR_OK & cfg.two_thr_mode;
   wire active = state_reg != iphs_pkg::IPHS_IDLE &&
                 state_reg != iphs_pkg::IPHS_EOINJ;

   // expiry is a single flag when a loaded count runs out
   assign first_counter_expiry = active && cnt1_reg == 16'h0001;
   assign second_counter_expiry = active && cnt2_reg == 16'h0001;

   // over threshold against reference; under uses low threshold
   function automatic logic above(input logic [9:0] i,
                                  input logic [9:0] t);
      above = i > t;
   endfunction

   wire peak_over = above(current, cfg.peak_thr);
   wire hold_over = above(current, cfg.hold_thr);
   wire peak_under = ~above(current, cfg.peak_lo_thr);
   wire hold_under = ~above(current, cfg.hold_lo_thr);
   // off-phase exit: fixed off time or lower threshold
   wire peak_back = two_thr ? peak_under : second_counter_expiry;
   wire hold_back = two_thr ? hold_under : first_counter_expiry;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         iphs_pkg::IPHS_IDLE: begin
            if (start_rise) begin
               state_next = peak_over ? iphs_pkg::IPHS_PEAK_OFF
                                      : iphs_pkg::IPHS_PEAK_ON;
            end
         end
         iphs_pkg::IPHS_PEAK_ON: begin
            if (first_counter_expiry) begin
               state_next = hold_over ? iphs_pkg::IPHS_HOLD_OFF
                                      : iphs_pkg::IPHS_HOLD_ON;
            end else if (peak_over) begin
               state_next = iphs_pkg::IPHS_PEAK_OFF;
            end
         end
         iphs_pkg::IPHS_PEAK_OFF: begin
            if (first_counter_expiry) begin
               state_next = hold_over ? iphs_pkg::IPHS_HOLD_OFF
                                      : iphs_pkg::IPHS_HOLD_ON;
            end else if (peak_back) begin
               state_next = iphs_pkg::IPHS_PEAK_ON;
            end
         end
         iphs_pkg::IPHS_HOLD_ON: begin
            if (second_counter_expiry) begin
               state_next = iphs_pkg::IPHS_EOINJ;
            end else if (hold_over) begin
               state_next = iphs_pkg::IPHS_HOLD_OFF;
            end
         end
         iphs_pkg::IPHS_HOLD_OFF: begin
            if (second_counter_expiry) begin
               state_next = iphs_pkg::IPHS_EOINJ;
            end else if (hold_back) begin
               state_next = iphs_pkg::IPHS_HOLD_ON;
            end
         end
         iphs_pkg::IPHS_EOINJ: begin
            // one cycle of energy return, then idle for next edge
            state_next = iphs_pkg::IPHS_IDLE;
         end
      endcase
      // start low ends the pulse from any active phase
      if (active && !start) begin
         state_next = iphs_pkg::IPHS_EOINJ;
      end
   end

   // -------------------------------------------------------------
   // switch pattern and comparator reference
   // -------------------------------------------------------------
   always_comb begin
      sw_next = '0; // idle, eoinj: all off
      unique case (state_next)
         iphs_pkg::IPHS_PEAK_ON: sw_next = '{boost: 1'b1, bat: 1'b0,
                                             low: 1'b1};
         iphs_pkg::IPHS_PEAK_OFF,
         iphs_pkg::IPHS_HOLD_OFF: sw_next = '{boost: 1'b0, bat: 1'b0,
                                              low: 1'b1};
         iphs_pkg::IPHS_HOLD_ON: sw_next = '{boost: 1'b0, bat: 1'b1,
                                             low: 1'b1};
         default: sw_next = '0;
      endcase
   end

   wire in_hold = state_next == iphs_pkg::IPHS_HOLD_ON ||
                  state_next == iphs_pkg::IPHS_HOLD_OFF;
   assign dac_next = in_hold ? cfg.hold_thr : cfg.peak_thr;

   // hard shorts turn the switch off until the next event
   wire [2:0] kill_now = {diag_boost.short_bat | diag_boost.short_gnd,
                          diag_bat.short_gnd,
                          diag_low.short_bat};
   wire sw_event = state_next != state_reg;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= iphs_pkg::IPHS_IDLE;
         start_reg <= 1'b0;
         sw_reg <= '0;
         dac_ref <= iphs_pkg::DAC_ZERO;
      end else begin
         state_reg <= state_next;
         start_reg <= start;
         sw_reg <= sw_next;
         dac_ref <= dac_next;
      end
   end

   // counter one: peak total, then hold off; counter two the rest
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt1_reg <= iphs_pkg::CNT_ZERO;
         cnt2_reg <= iphs_pkg::CNT_ZERO;
      end else begin
         if (state_reg == iphs_pkg::IPHS_IDLE && start_rise) begin
            cnt1_reg <= cfg.peak_tot;
         end else if (state_next == iphs_pkg::IPHS_HOLD_OFF &&
                      state_reg != iphs_pkg::IPHS_HOLD_OFF) begin
            cnt1_reg <= cfg.hold_off;
         end else if (cnt1_reg != iphs_pkg::CNT_ZERO) begin
            cnt1_reg <= cnt1_reg - 16'h0001;
         end
         if (state_next == iphs_pkg::IPHS_PEAK_OFF &&
             state_reg != iphs_pkg::IPHS_PEAK_OFF) begin
            cnt2_reg <= cfg.peak_off;
         end else if ((state_next == iphs_pkg::IPHS_HOLD_ON ||
                       state_next == iphs_pkg::IPHS_HOLD_OFF) &&
                      !(state_reg == iphs_pkg::IPHS_HOLD_ON ||
                        state_reg == iphs_pkg::IPHS_HOLD_OFF)) begin
            cnt2_reg <= cfg.hold_tot;
         end else if (cnt2_reg != iphs_pkg::CNT_ZERO) begin
            cnt2_reg <= cnt2_reg - 16'h0001;
         end
      end
   end

   // fault latch, released at the next switching event
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         kill_reg <= 3'h0;
         fault_report <= 3'h0;
         reached_reg <= 1'b0;
         no_target_current <= 1'b0;
         no_boost_voltage <= 1'b0;
      end else begin
         // a short still present at the event keeps the switch off
         kill_reg <= (sw_event ? 3'h0 : kill_reg) | kill_now;
         fault_report <= {|diag_boost, |diag_bat, |diag_low};
         no_boost_voltage <= (sw_reg.boost & ~boost_ok);
         // missed target: total timer ends without a crossing
         if (sw_event) begin
            reached_reg <= 1'b0;
         end else if (peak_over || hold_over) begin
            reached_reg <= 1'b1;
         end
         no_target_current <= (first_counter_expiry ||
                               second_counter_expiry) &&
                              !reached_reg &&
                              (state_reg == iphs_pkg::IPHS_PEAK_ON ||
                               state_reg == iphs_pkg::IPHS_HOLD_ON);
      end
   end

   // open load and soft faults leave the switch on
   wire [2:0] gated_sw = sw_reg & ~kill_reg;
   assign high_side_switch = iphs_pkg::iphs_sw_t'(gated_sw);
   assign low_side_switch = gated_sw[0];

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_idle_all_off: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_IDLE |-> sw_reg == '0)
      else $error("switches on while idle");
   a_start_drop_end: assert property (@(posedge mclk)
      disable iff (!reset_n) active && !start
      |=> state_reg == iphs_pkg::IPHS_EOINJ)
      else $error("start low did not end pulse");
   a_eoinj_all_off: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_EOINJ |-> sw_reg == '0)
      else $error("switches on in end of injection");
   a_peak_on_pat: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_PEAK_ON |-> sw_reg.boost && sw_reg.low
      && !sw_reg.bat)
      else $error("wrong peak drive pattern");
   a_hold_on_pat: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_HOLD_ON |-> sw_reg.bat && sw_reg.low
      && !sw_reg.boost)
      else $error("wrong hold drive pattern");
   a_rise_starts: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_IDLE && start_rise
      |=> state_reg inside {iphs_pkg::IPHS_PEAK_ON,
                            iphs_pkg::IPHS_PEAK_OFF})
      else $error("rising start did not begin peak");
   a_peak_cross: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_PEAK_ON && start && peak_over
      && !first_counter_expiry
      |=> state_reg == iphs_pkg::IPHS_PEAK_OFF
      && cnt2_reg == cfg.peak_off)
      else $error("peak crossing not handled");
   a_hold_total_end: assert property (@(posedge mclk)
      disable iff (!reset_n) start && second_counter_expiry &&
      state_reg inside {iphs_pkg::IPHS_HOLD_ON, iphs_pkg::IPHS_HOLD_OFF}
      |=> state_reg == iphs_pkg::IPHS_EOINJ ##1
      state_reg == iphs_pkg::IPHS_IDLE)
      else $error("hold total expiry missed");
   a_recirc_pat: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg inside {iphs_pkg::IPHS_PEAK_OFF, iphs_pkg::IPHS_HOLD_OFF}
      |-> !sw_reg.boost && !sw_reg.bat && sw_reg.low)
      else $error("wrong recirculation pattern");
   a_peak_total_end: assert property (@(posedge mclk)
      disable iff (!reset_n) start && first_counter_expiry &&
      state_reg inside {iphs_pkg::IPHS_PEAK_ON, iphs_pkg::IPHS_PEAK_OFF}
      |=> state_reg inside {iphs_pkg::IPHS_HOLD_ON,
                            iphs_pkg::IPHS_HOLD_OFF})
      else $error("peak total expiry missed");
   a_hold_entry: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg inside {iphs_pkg::IPHS_PEAK_ON, iphs_pkg::IPHS_PEAK_OFF} &&
      state_next inside {iphs_pkg::IPHS_HOLD_ON, iphs_pkg::IPHS_HOLD_OFF}
      |=> cnt2_reg == cfg.hold_tot && dac_ref == cfg.hold_thr)
      else $error("hold entry loads missed");
   a_hold_cross: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == iphs_pkg::IPHS_HOLD_ON && start && hold_over
      && !second_counter_expiry
      |=> state_reg == iphs_pkg::IPHS_HOLD_OFF
      && cnt1_reg == cfg.hold_off)
      else $error("hold crossing not handled");
   a_short_kill: assert property (@(posedge mclk) disable iff (!reset_n)
      diag_boost.short_gnd |=> !high_side_switch.boost)
      else $error("boost switch left on into a short");
endmodule
